// File: test/analog_pins_model.sv
/*
 * Far-side model: twelve analog input pins feeding the comparator.
 * Assumes the block routes one input one-hot and drives the trial code.
 */
`timescale 1ns/1ps
module analog_pins_model (
    // Block side, and the level base set by the bench.
    input wire logic [11:0] inputRoute,
    input wire logic [11:0] pinAnalog,
    input wire logic [9:0] dacTrial,
    input wire logic [9:0] levelBase,
    // Comparator.
    output logic cmpIn
);
    // Each level sits half a step above its code, so equal reads above.
    // A digital pin or an unrouted input gives the comparator nothing.
    always_comb begin
        cmpIn = 1'b0;
        for (int n = 0; n < 12; n++) begin
            if (inputRoute[n] && pinAnalog[n]) begin
                cmpIn = (levelBase + 10'(n * 37)) >= dacTrial;
            end
        end
    end
endmodule // analog_pins_model

// File: test/tb_adc_channel_and_pin_control.sv
/*
 * Self-checking bench for the converter control block.
 * Assumes the analog pins model and a classic Wishbone master.
 */
`timescale 1ns/1ps
module tb_adc_channel_and_pin_control;
    import adc_ctrl_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [3:0] sel = 4'h1;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic cmpIn;
    logic [11:0] inputRoute;
    logic [11:0] pinAnalog;
    logic negRefPin;
    logic posRefPin;
    logic [9:0] dacTrial;
    logic sampling;
    logic [9:0] levelBase = 10'h2a7;
    logic calibrating;
    logic irq;
    logic [7:0] rd;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;
    int calCycles = 0;
    int convCycles = 0;

    always #2 mclk = ~mclk;

    adc_channel_and_pin_control i_dut (.mclk(mclk), .rst(rst),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .cmpIn(cmpIn),
        .inputRoute(inputRoute), .pinAnalog(pinAnalog),
        .negRefPin(negRefPin), .posRefPin(posRefPin), .dacTrial(dacTrial),
        .sampling(sampling), .calibrating(calibrating), .irq(irq));

    analog_pins_model i_pins (.inputRoute(inputRoute),
        .pinAnalog(pinAnalog), .dacTrial(dacTrial),
        .levelBase(levelBase), .cmpIn(cmpIn));

    // ********************************
    // Checking and bus tasks
    // ********************************
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (calibrating === 1'b1) begin
            calCycles++;
        end
        // Cycles spent converting while an input is routed.
        if (sampling === 1'b0 && inputRoute !== 12'h000) begin
            convCycles++;
        end
        if (cycles == 20000) begin
            bad_count++;
            $display("MISMATCH t=%0t run timed out", $time);
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Holds the request until ack is sampled, then releases it.
    task automatic wb(input logic w, input logic [4:0] a,
        input logic [7:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        chk(32'(ack), 32'h1);
        rd = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
        wb(1'b0, a, 8'h00);
        chk(32'(rd), 32'(exp));
    endtask

    task automatic settle();
        repeat (2) @(negedge mclk);
    endtask

    // ********************************
    // Scenarios
    // ********************************
    task automatic t_reset();
        chk(32'(pinAnalog), 32'hfff);
        rdchk(OFF_CTRL_MAIN, 8'h00);
        rdchk(OFF_REF_PINS, 8'h00);
        rdchk(OFF_TIMING, 8'h00);
        rdchk(5'h1c, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_bits();
        wb(1'b1, OFF_CTRL_MAIN, 8'h42);
        rdchk(OFF_CTRL_MAIN, 8'h00);
        wb(1'b1, OFF_CTRL_MAIN, 8'hc0);
        rdchk(OFF_CTRL_MAIN, 8'h80);
        wb(1'b1, OFF_REF_PINS, 8'hff);
        rdchk(OFF_REF_PINS, 8'h3f);
        for (int i = 0; i < 2; i++) begin
            wb(1'b1, OFF_REF_PINS, 8'h20 >> i);
            settle();
            chk(32'({negRefPin, posRefPin}), 32'(2'b10 >> i));
        end
        $display("test bits done");
    endtask

    task automatic t_pins();
        for (int c = 0; c < 16; c++) begin
            wb(1'b1, OFF_REF_PINS, 8'(c));
            settle();
            chk(32'(pinAnalog), c < 4 ? 32'hfff : 32'(12'hfff >> (c - 3)));
        end
        $display("test pins done");
    endtask

    task automatic t_chan();
        for (int c = 0; c < 16; c++) begin
            wb(1'b1, OFF_CTRL_MAIN, 8'((c << 2) | 1));
            settle();
            chk(32'(inputRoute), c < 12 ? 32'h1 << c : 32'h0);
        end
        wb(1'b1, OFF_CTRL_MAIN, 8'h14);
        settle();
        chk(32'(inputRoute), 32'h0);
        chk(32'(sampling), 32'h0);
        $display("test channels done");
    endtask

    task automatic t_conv(input logic just, input logic cal,
        input logic [2:0] code, input int div);
        int n;
        int c0;
        int k0;
        logic [9:0] r;
        r = levelBase + 10'(5 * 37);
        n = 0;
        wb(1'b1, OFF_REF_PINS, 8'h00);
        wb(1'b1, OFF_TIMING, {just, 4'h0, code});
        wb(1'b1, OFF_IRQ_MASK, 8'h01);
        c0 = calCycles;
        k0 = convCycles;
        wb(1'b1, OFF_CTRL_MAIN, {cal, 7'h17});
        rdchk(OFF_CTRL_MAIN, {cal, 7'h17});
        do begin
            wb(1'b0, OFF_CTRL_MAIN, 8'h00);
            n++;
        end while (rd[1] !== 1'b0 && n < 100);
        chk(32'(rd[1]), 32'h0);
        chk(32'(convCycles - k0), 32'((cal ? 12 : 11) * div + 1));
        chk(32'(sampling), 32'h1);
        if (!cal) begin
            rdchk(OFF_RES_HIGH, just ? {6'h0, r[9:8]} : r[9:2]);
            rdchk(OFF_RES_LOW, just ? r[7:0] : {r[1:0], 6'h0});
        end
        chk(32'(calCycles > c0), 32'(cal));
        rdchk(OFF_IRQ_STATUS, 8'h01);
        settle();
        chk(32'(irq), 32'h1);
        wb(1'b1, OFF_IRQ_MASK, 8'h00);
        settle();
        chk(32'(irq), 32'h0);
        wb(1'b1, OFF_IRQ_MASK, 8'h01);
        wb(1'b1, OFF_IRQ_STATUS, 8'h01);
        settle();
        chk(32'(irq), 32'h0);
        rdchk(OFF_IRQ_STATUS, 8'h00);
        $display("test conversion done");
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_bits();
        t_pins();
        t_chan();
        t_conv(1'b1, 1'b0, 3'h0, 2);
        t_conv(1'b0, 1'b0, 3'h4, 4);
        t_conv(1'b0, 1'b1, 3'h1, 8);
        results();
    end
endmodule // tb_adc_channel_and_pin_control

// File: verilog/adc_channel_and_pin_control.sv
/*
 * Register and sequencing side of a 10-bit converter with twelve inputs.
 * Assumes a classic Wishbone master and a comparator level on cmpIn.
 */
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
module adc_channel_and_pin_control
    import adc_ctrl_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Wishbone slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Analog side.
    input wire logic cmpIn,
    output logic [11:0] inputRoute,
    output logic [11:0] pinAnalog,
    output logic negRefPin,
    output logic posRefPin,
    output logic [9:0] dacTrial,
    output logic sampling,
    output logic calibrating,
    // Interrupt.
    output logic irq
);
    typedef enum logic [1:0] {IDLE, ACQ, CONV} phase_type;
    typedef struct packed {
        phase_type phase;
        logic calNext;
        logic [3:0] chan;
        logic go;
        logic on;
        logic [5:0] refPins;
        logic [7:0] timing;
        logic [9:0] result;
        logic doneFlag;
        logic doneMask;
        logic [7:0] div;
        logic tick;
        logic [4:0] acqLeft;
        logic calRun;
        logic ack;
        logic [31:0] rdata;
    } state_type;
    state_type s_q, s_d;
    conv_if cv ();

    // ******************************************
    // Helpers
    // ******************************************
    function automatic logic [4:0] acqPeriods(input logic [2:0] code);
        case (code)
            3'h0: acqPeriods = 5'h00;
            3'h1: acqPeriods = 5'h02;
            3'h2: acqPeriods = 5'h04;
            3'h3: acqPeriods = 5'h06;
            3'h4: acqPeriods = 5'h08;
            3'h5: acqPeriods = 5'h0c;
            3'h6: acqPeriods = 5'h10;
            default: acqPeriods = 5'h14;
        endcase
    endfunction

    function automatic logic [7:0] divCycles(input logic [2:0] code);
        case (code)
            3'h0: divCycles = 8'h02;
            3'h1: divCycles = 8'h08;
            3'h2: divCycles = 8'h20;
            3'h4: divCycles = 8'h04;
            3'h5: divCycles = 8'h10;
            3'h6: divCycles = 8'h40;
            default: divCycles = RC_TAD_CYC;
        endcase
    endfunction

    function automatic logic [7:0] mergeByte(input logic [7:0] old,
            input logic [31:0] wd, input logic [3:0] sel);
        mergeByte = sel[0] ? wd[7:0] : old;
    endfunction

    // ******************************************
    // Next state
    // ******************************************
    logic wbReq;
    logic wrHit;
    logic [7:0] wb;
    logic [7:0] ctrlRd;
    assign wbReq = cyc_i && stb_i && !s_q.ack;
    assign wrHit = wbReq && we_i && sel_i[0];

    always_comb begin
        s_d = s_q;
        s_d.ack = wbReq;
        s_d.tick = 1'b0;
        wb = 8'h00;
        ctrlRd = {s_q.calNext, 1'b0, s_q.chan, s_q.go && s_q.on, s_q.on};
        // Conversion clock divider.
        if (s_q.phase == IDLE) begin
            s_d.div = 8'h00;
        end else if (s_q.div + 8'h01 >= divCycles(s_q.timing[2:0])) begin
            s_d.div = 8'h00;
            s_d.tick = 1'b1;
        end else begin
            s_d.div = s_q.div + 8'h01;
        end
        // Register writes.
        if (wrHit) begin
            case (adr_i)
                OFF_CTRL_MAIN: begin
                    wb = mergeByte(8'h00, dat_i, sel_i);
                    s_d.calNext = wb[CAL_BIT];
                    s_d.chan = wb[CHS_LSB +: 4];
                    s_d.on = wb[ON_BIT];
                    // A go written while disabled is dropped.
                    s_d.go = wb[GO_BIT] && wb[ON_BIT];
                end
                OFF_REF_PINS: s_d.refPins = dat_i[5:0];
                OFF_TIMING: s_d.timing = {dat_i[7], 1'b0, dat_i[5:0]};
                OFF_IRQ_MASK: s_d.doneMask = dat_i[0];
                default: ;
            endcase
        end
        // Sequencer.
        case (s_q.phase)
            IDLE: begin
                if (s_d.go && !s_q.go && s_d.on) begin
                    s_d.phase = ACQ;
                    s_d.acqLeft = acqPeriods(s_q.timing[5:3]);
                    s_d.calRun = s_d.calNext;
                end
            end
            ACQ: begin
                if (s_q.acqLeft == 5'h00) begin
                    s_d.phase = CONV;
                end else if (s_q.tick) begin
                    s_d.acqLeft = s_q.acqLeft - 5'h01;
                end
            end
            CONV: begin
                if (cv.done) begin
                    s_d.phase = IDLE;
                    s_d.result = cv.result;
                    s_d.go = 1'b0;
                    s_d.calRun = 1'b0;
                end
            end
            default: s_d.phase = IDLE;
        endcase
        // Turning the module off aborts any conversion.
        if (!s_d.on) begin
            s_d.phase = IDLE;
            s_d.go = 1'b0;
        end
        // Done flag: a write of one clears, a completion sets and wins.
        if (wrHit && adr_i == OFF_IRQ_STATUS && dat_i[0]) begin
            s_d.doneFlag = 1'b0;
        end
        if (s_q.phase == CONV && cv.done) begin
            s_d.doneFlag = 1'b1;
        end
        // Read data.
        s_d.rdata = 32'h0;
        if (wbReq && !we_i) begin
            case (adr_i)
                OFF_CTRL_MAIN: s_d.rdata = {24'h0, ctrlRd};
                OFF_REF_PINS: s_d.rdata = {26'h0, s_q.refPins};
                OFF_TIMING: s_d.rdata = {24'h0, s_q.timing};
                OFF_RES_HIGH: s_d.rdata = s_q.timing[JUST_BIT] ?
                    {30'h0, s_q.result[9:8]} : {24'h0, s_q.result[9:2]};
                OFF_RES_LOW: s_d.rdata = s_q.timing[JUST_BIT] ?
                    {24'h0, s_q.result[7:0]} : {24'h0, s_q.result[1:0], 6'h0};
                OFF_IRQ_STATUS: s_d.rdata = {31'h0, s_q.doneFlag};
                OFF_IRQ_MASK: s_d.rdata = {31'h0, s_q.doneMask};
                default: s_d.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.phase <= IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ******************************************
    // Engine and outputs
    // ******************************************
    assign cv.start = (s_q.phase == ACQ) && (s_q.acqLeft == 5'h00);
    assign cv.cal = s_q.calRun;
    assign cv.tadTick = s_q.tick;
    assign cv.cmpIn = cmpIn;

    sar_engine engine (
        .mclk(mclk),
        .rst(rst),
        .cv(cv)
    );

    always_comb begin
        inputRoute = 12'h000;
        if (s_q.on && s_q.chan <= MAX_CHAN) begin
            inputRoute = 12'(12'h001 << s_q.chan);
        end
    end

    always_comb begin
        pinAnalog = 12'hfff;
        if (s_q.refPins[3:0] >= 4'h4) begin
            pinAnalog = 12'(12'hfff >> (s_q.refPins[3:0] - 4'h3));
        end
    end

    assign negRefPin = s_q.refPins[NREF_BIT];
    assign posRefPin = s_q.refPins[PREF_BIT];
    assign dacTrial = cv.trial;
    assign sampling = s_q.on && s_q.phase != CONV;
    assign calibrating = s_q.calRun;
    assign dat_o = s_q.rdata;
    assign ack_o = s_q.ack;
    assign irq = s_q.doneFlag && s_q.doneMask;

    // ******************************************
    // Checks
    // ******************************************
    go_needs_on_a: assert property (@(posedge mclk) disable iff (rst)
        !s_q.on |-> !s_q.go) else $error("go set while disabled");
    done_clears_go_a: assert property (
        @(posedge mclk) disable iff (rst)
        (s_q.phase == CONV && cv.done && s_q.on) |=>
        (!s_q.go && s_q.doneFlag)) else $error("completion not recorded");
    no_acq_zero_a: assert property (@(posedge mclk) disable iff (rst)
        cv.start |=> (s_q.phase == CONV || !s_q.on))
        else $error("acquisition did not end in conversion");
    route_onehot_a: assert property (@(posedge mclk) disable iff (rst)
        $onehot0(inputRoute)) else $error("several inputs routed");
    pins_all_a: assert property (@(posedge mclk) disable iff (rst)
        s_q.refPins[3:2] == 2'b00 |-> pinAnalog == 12'hfff)
        else $error("low pin code not all analog");
    pins_none_a: assert property (@(posedge mclk) disable iff (rst)
        s_q.refPins[3:0] == 4'hf |-> pinAnalog == 12'h000)
        else $error("code all ones not all digital");
    bit_six_a: assert property (@(posedge mclk) disable iff (rst)
        ack_o && !$past(we_i) && $past(adr_i) == OFF_CTRL_MAIN |->
        dat_o[6] == 1'b0) else $error("unimplemented bit set");
    irq_gate_a: assert property (@(posedge mclk) disable iff (rst)
        (s_q.phase == CONV && cv.done && s_q.doneMask) |=>
        (irq || !s_q.doneMask)) else $error("done did not raise irq");
endmodule // adc_channel_and_pin_control

// File: verilog/adc_ctrl_pkg.sv
/*
 * Constants for the converter control block: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 250 MHz system clock and a 32-bit classic Wishbone bus.
 */
package adc_ctrl_pkg;
    // Register byte offsets.
    localparam logic [4:0] OFF_CTRL_MAIN = 5'h00;
    localparam logic [4:0] OFF_REF_PINS = 5'h04;
    localparam logic [4:0] OFF_TIMING = 5'h08;
    localparam logic [4:0] OFF_RES_HIGH = 5'h0c;
    localparam logic [4:0] OFF_RES_LOW = 5'h10;
    localparam logic [4:0] OFF_IRQ_STATUS = 5'h14;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h18;
    // Field positions.
    localparam int CAL_BIT = 7;
    localparam int CHS_LSB = 2;
    localparam int GO_BIT = 1;
    localparam int ON_BIT = 0;
    localparam int NREF_BIT = 5;
    localparam int PREF_BIT = 4;
    localparam int JUST_BIT = 7;
    localparam int ACQ_LSB = 3;
    // Reset values.
    localparam logic [7:0] RST_CTRL = 8'h00;
    // Conversion figures.
    localparam int NUM_INPUTS = 12;
    localparam int RES_BITS = 10;
    localparam logic [3:0] MAX_CHAN = 4'hb;
    localparam logic [4:0] CONV_TAD = 5'h0b;
    localparam logic [4:0] CAL_TAD = 5'h0c;
    // Internal RC conversion clock period in ns, and its cycle count.
    localparam int RC_TAD_NS = 1000;
    localparam int CLK_NS = 4;
    localparam logic [7:0] RC_TAD_CYC = 8'(RC_TAD_NS / CLK_NS);
endpackage

// File: verilog/conv_if.sv
/*
 * Interface between the control block and its successive approximation
 * engine. Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
interface conv_if;
    logic start;
    logic cal;
    logic tadTick;
    logic cmpIn;
    logic [9:0] trial;
    logic done;
    logic [9:0] result;
    modport ctrl (output start, output cal, output tadTick,
        input trial, input done, input result);
    modport eng (input start, input cal, input tadTick, input cmpIn,
        output trial, output done, output result);
endinterface

// File: verilog/sar_engine.sv
/*
 * Successive approximation engine: one bit decision per conversion clock.
 * Assumes the comparator level is synchronous to mclk.
 */
`timescale 1ns/1ps
module sar_engine
    import adc_ctrl_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Control side.
    conv_if.eng cv
);
    typedef struct packed {
        logic busy;
        logic [4:0] steps;
        logic [9:0] trial;
        logic [9:0] bitPos;
        logic done;
        logic [9:0] result;
    } eng_type;
    eng_type s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (cv.start) begin
            s_d.busy = 1'b1;
            s_d.steps = cv.cal ? CAL_TAD : CONV_TAD;
            s_d.bitPos = 10'h200;
            s_d.trial = 10'h200;
        end else if (s_q.busy && cv.tadTick) begin
            // The first period settles, or the first two when calibrating; the next ten decide bits.
            if (s_q.steps <= 5'(RES_BITS)) begin
                s_d.trial = cv.cmpIn ? s_q.trial : s_q.trial & ~s_q.bitPos;
                s_d.bitPos = s_q.bitPos >> 1;
                s_d.trial = s_d.trial | (s_q.bitPos >> 1);
            end
            s_d.steps = s_q.steps - 5'h01;
            if (s_q.steps == 5'h01) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.result = s_d.trial;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cv.trial = s_q.trial;
    assign cv.done = s_q.done;
    assign cv.result = s_q.result;
endmodule // sar_engine
